// ===== hw/mfs_consts.vh
// Purpose: shared constants of the frame security sequencer
// Assumes: byte-wide frame buffers, one device clock
// Notes:   definitions only
`ifndef MFS_CONSTS_VH
`define MFS_CONSTS_VH

// frame buffer base addresses
`define MFS_TX_BUF_BASE   10'h200
`define MFS_RX_BUF_BASE   10'h300
// security material addresses (host side)
`define MFS_KEY_LSB_ADDR  8'h40
`define MFS_NONCE_MSB_ADDR 8'h5C

// frame type codes, standard format (3 bits)
`define MFS_STD_BEACON    3'h0
`define MFS_STD_DATA      3'h1
`define MFS_STD_ACK       3'h2
`define MFS_STD_CMD       3'h3
// frame type codes, proprietary format (2 bits)
`define MFS_PRP_STREAM    2'h0
`define MFS_PRP_DATA      2'h1
`define MFS_PRP_ACK       2'h2
`define MFS_PRP_CMD       2'h3

// frame control field positions
`define MFS_STD_TYPE_LSB  0
`define MFS_STD_ACK_REQUEST_FLAG    5
`define MFS_PRP_TYPE_LSB  6
`define MFS_PRP_ACK_REQUEST_FLAG    13

// direction select modes
`define MFS_DIR_STREAM_TX 2'h1
`define MFS_DIR_STREAM_RX 2'h2

// frame layout: length byte at 0, frame control from 1
`define MFS_HDR_INDEX     8'h01
`define MFS_CRC_BYTES     8'h02
`define MFS_ACK_LEN       8'h05
`define MFS_ACK_FC_STD    16'h0002
`define MFS_ACK_FC_PRP    16'h0080
`define MFS_MAX_LEN       8'h7F

`endif

// ===== hw/mfs_type_decode.v
// Purpose: frame type classification and type-based rejection
// Assumes: frame control field presented as a 16-bit word
// Notes:   purely combinational
`timescale 1ns/100ps
`include "mfs_consts.vh"

module mfs_type_decode (
    input  wire [15:0] frameControl,  // frame control field
    input  wire        propFormat,    // 1 = proprietary format
    input  wire        dataReject,    // data type reject
    input  wire        cmdReject,     // command type reject
    input  wire        beaconReject,  // beacon type reject
    output reg         isData,        // data frame
    output reg         isCmd,         // command frame
    output reg         isAck,         // acknowledge frame
    output reg         isBeacon,      // beacon frame
    output reg         isStream,      // streaming frame
    output reg         ack_request_flag,        // acknowledge requested
    output reg         reject         // frame to be discarded
);

    reg [2:0] stdType;
    reg [1:0] prpType;

    // decode type codes of both formats
    always @* begin
        stdType  = frameControl[`MFS_STD_TYPE_LSB +: 3];
        prpType  = frameControl[`MFS_PRP_TYPE_LSB +: 2];
        isData   = 1'b0;
        isCmd    = 1'b0;
        isAck    = 1'b0;
        isBeacon = 1'b0;
        isStream = 1'b0;
        if (propFormat) begin
            isData   = (prpType == `MFS_PRP_DATA);
            isCmd    = (prpType == `MFS_PRP_CMD);
            isAck    = (prpType == `MFS_PRP_ACK);
            isStream = (prpType == `MFS_PRP_STREAM);
            ack_request_flag   = frameControl[`MFS_PRP_ACK_REQUEST_FLAG];
        end else begin
            isData   = (stdType == `MFS_STD_DATA);
            isCmd    = (stdType == `MFS_STD_CMD);
            isAck    = (stdType == `MFS_STD_ACK);
            isBeacon = (stdType == `MFS_STD_BEACON);
            ack_request_flag   = frameControl[`MFS_STD_ACK_REQUEST_FLAG];
        end
        reject = (dataReject & isData)
               | (cmdReject & isCmd)
               | (beaconReject & isBeacon);
    end

endmodule

// ===== hw/mfs_two_entry_buf.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty are exact; no word lost on a stall
`timescale 1ns/100ps

module mfs_two_entry_buf #(
    parameter WIDTH = 8                // word width
) (
    input  wire             clk,       // device clock
    input  wire             srst,      // synchronous reset
    input  wire [WIDTH-1:0] inData,    // word in
    input  wire             inValid,   // word in valid
    output wire             inReady,   // room for a word
    output wire [WIDTH-1:0] outData,   // word out
    output wire             outValid,  // word out valid
    input  wire             outReady   // receiver takes word
);

    reg [WIDTH-1:0] mem [0:1];
    reg             wrPtr_q;
    reg             rdPtr_q;
    reg [1:0]       count_q;
    wire            push;
    wire            pop;

    assign inReady  = (count_q != 2'h2);
    assign outValid = (count_q != 2'h0);
    assign outData  = mem[rdPtr_q];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // storage and pointers
    always @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
        if (srst) begin
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                wrPtr_q <= ~wrPtr_q;
            end
            if (pop) begin
                rdPtr_q <= ~rdPtr_q;
            end
            if (push & ~pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop & ~push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end

endmodule

// ===== hw/mfs_sequencer.v
// Purpose: security sequencing, frame classification, hw acknowledge
// Assumes: cipher datapath, CRC and radio outside; inputs synchronous
// Notes:   host triggers are one-cycle pulses; flags are sticky
`timescale 1ns/100ps
`include "mfs_consts.vh"

module mfs_sequencer #(
    parameter IDX_W = 8                    // buffer index width
) (
    input  wire             clk,           // device clock
    input  wire             srst,          // synchronous reset
    // host side
    input  wire             netEncryptTrigger,  // set encrypt trigger
    input  wire             transmitStart,      // set transmit start
    input  wire             decryptTrigger,     // set decrypt trigger
    input  wire             manualSecuritySetup,// host fills materials
    input  wire             propFormat,         // proprietary format
    input  wire             dataTypeReject,     // discard data frames
    input  wire             commandTypeReject,  // discard commands
    input  wire             beaconTypeReject,   // discard beacons
    input  wire             hwAckEnable,        // hardware acknowledge
    input  wire             crcAppendEnable,    // append CRC
    input  wire [1:0]       transceiverDirectionSelect, // stream mode
    input  wire [5:0]       flagClear,     // clear sticky flags
    output reg              netEncryptBusy_q,   // encrypt trigger
    output reg              transmitBusy_q,     // transmit start
    output reg              decryptBusy_q,      // decrypt trigger
    output reg              encryptDoneFlag_q,  // encrypt done
    output reg              decryptDoneFlag_q,  // decrypt done
    output reg              authFailFlag_q,     // tag mismatch
    output reg              idleFlag_q,         // encrypt-only or decrypt run finished
    output reg              rxFrameFlag_q,      // frame accepted
    output reg              rxDelimiterFlag_q,  // delimiter seen
    // transmit frame header, parsed outside
    input  wire [15:0]      txFrameControl,// frame control field
    input  wire             txSecEnable,   // security enabled bit
    input  wire [7:0]       txSecLevel,    // auxiliary level
    input  wire [IDX_W-1:0] txPayloadStart,// first payload byte
    input  wire [7:0]       txLength,      // current length byte
    // security material outputs
    output reg  [7:0]       suiteSelect_q,      // derived suite
    output reg  [IDX_W-1:0] authHeaderIndex_q,  // header index
    output reg  [IDX_W-1:0] cryptPayloadIndex_q,// payload index
    output reg  [IDX_W-1:0] cryptEndIndex_q,    // end index
    output reg              nonceFill_q,        // derive nonce pulse
    // cipher datapath
    output reg              cipherStart_q, // start pulse
    output reg              cipherDecrypt_q, // 1 = verify/decrypt
    output reg  [9:0]       cipherBase_q,  // buffer base address
    input  wire             cipherDone,    // operation finished
    input  wire             cipherAuthOk,  // tag matched
    input  wire [4:0]       cipherMicLen,  // appended tag bytes
    // length byte write-back
    output reg              lengthWrite_q, // write length byte
    output reg  [7:0]       lengthValue_q, // new length
    output reg              sizeOverrun_q, // length over maximum
    // radio
    output reg              txLaunch_q,    // send frame pulse
    input  wire             txSent,        // frame sent
    input  wire             rxFrameValid,  // frame passed CRC
    input  wire [15:0]      rxFrameControl,// received control
    input  wire [7:0]       rxSeqNum,      // received sequence
    output reg              rxDiscard_q,   // frame discarded
    output reg              activeBuffer_q,// streaming buffer
    output wire [7:0]       ackByte,       // acknowledge byte
    output wire             ackValid,      // acknowledge byte valid
    input  wire             ackReady       // radio takes byte
);

    localparam ST_IDLE  = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_ENC   = 3'h2;
    localparam ST_DEC   = 3'h3;
    localparam ST_SEND  = 3'h4;
    localparam [15:0] ACK_FC_STD = `MFS_ACK_FC_STD;
    localparam [15:0] ACK_FC_PRP = `MFS_ACK_FC_PRP;

    reg [2:0]  state_q;
    reg [2:0]  state_d;
    reg        forSend_q;
    reg [2:0]  ackCnt_q;
    reg [7:0]  ackSeq_q;
    reg        ackProp_q;
    reg [7:0]  ackWord;
    wire       ackInReady;
    wire       ackPush;
    wire       txIsCmd;
    wire       rxIsData;
    wire       rxIsCmd;
    wire       rxIsAck;
    wire       rxIsBeacon;
    wire       rxIsStream;
    wire       rxAckReq;
    wire       rxReject;
    wire       streamMode;
    wire [8:0] grown;

    // length after appending bytes, with the carry kept in a ninth bit
    function [8:0] addLen;
        input [7:0] len;
        input [7:0] extra;
        begin
            addLen = {1'b0, len} + {1'b0, extra};
        end
    endfunction

    mfs_type_decode uTxType (
        .frameControl (txFrameControl),
        .propFormat   (propFormat),
        .dataReject   (1'b0),
        .cmdReject    (1'b0),
        .beaconReject (1'b0),
        .isData       (),
        .isCmd        (txIsCmd),
        .isAck        (),
        .isBeacon     (),
        .isStream     (),
        .ack_request_flag       (),
        .reject       ()
    );

    mfs_type_decode uRxType (
        .frameControl (rxFrameControl),
        .propFormat   (propFormat),
        .dataReject   (dataTypeReject),
        .cmdReject    (commandTypeReject),
        .beaconReject (beaconTypeReject),
        .isData       (rxIsData),
        .isCmd        (rxIsCmd),
        .isAck        (rxIsAck),
        .isBeacon     (rxIsBeacon),
        .isStream     (rxIsStream),
        .ack_request_flag       (rxAckReq),
        .reject       (rxReject)
    );

    assign streamMode =
        (transceiverDirectionSelect == `MFS_DIR_STREAM_TX) |
        (transceiverDirectionSelect == `MFS_DIR_STREAM_RX);
    assign grown = addLen(txLength,
        {3'h0, cipherMicLen} + (crcAppendEnable ? `MFS_CRC_BYTES
                                                : 8'h00));

    // next state of the security sequence
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (netEncryptBusy_q) begin
                    state_d = ST_ENC;
                end else if (transmitBusy_q) begin
                    if (txSecEnable & ~manualSecuritySetup) begin
                        state_d = ST_SETUP;
                    end else if (txSecEnable) begin
                        state_d = ST_ENC;
                    end else begin
                        state_d = ST_SEND;
                    end
                end else if (decryptBusy_q) begin
                    state_d = ST_DEC;
                end
            end
            ST_SETUP: state_d = ST_ENC;
            ST_ENC: begin
                if (cipherDone) begin
                    state_d = forSend_q ? ST_SEND : ST_IDLE;
                end
            end
            ST_DEC: begin
                if (cipherDone) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SEND: begin
                if (txSent) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // sequence registers, triggers and cipher control
    always @(posedge clk) begin
        if (srst) begin
            state_q             <= ST_IDLE;
            forSend_q           <= 1'b0;
            netEncryptBusy_q    <= 1'b0;
            transmitBusy_q      <= 1'b0;
            decryptBusy_q       <= 1'b0;
            suiteSelect_q       <= 8'h00;
            authHeaderIndex_q   <= {IDX_W{1'b0}};
            cryptPayloadIndex_q <= {IDX_W{1'b0}};
            cryptEndIndex_q     <= {IDX_W{1'b0}};
            nonceFill_q         <= 1'b0;
            cipherStart_q       <= 1'b0;
            cipherDecrypt_q     <= 1'b0;
            cipherBase_q        <= `MFS_TX_BUF_BASE;
            lengthWrite_q       <= 1'b0;
            lengthValue_q       <= 8'h00;
            sizeOverrun_q       <= 1'b0;
            txLaunch_q          <= 1'b0;
            activeBuffer_q      <= 1'b0;
        end else begin
            state_q       <= state_d;
            nonceFill_q   <= 1'b0;
            cipherStart_q <= 1'b0;
            lengthWrite_q <= 1'b0;
            txLaunch_q    <= 1'b0;
            // host sets triggers; device clears them on completion
            if (netEncryptTrigger) begin
                netEncryptBusy_q <= 1'b1;
            end
            if (transmitStart) begin
                transmitBusy_q <= 1'b1;
            end
            if (decryptTrigger) begin
                decryptBusy_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    forSend_q <= ~netEncryptBusy_q & transmitBusy_q;
                    cipherDecrypt_q <= ~netEncryptBusy_q &
                                       ~transmitBusy_q;
                    cipherBase_q <=
                        (~netEncryptBusy_q & ~transmitBusy_q)
                        ? `MFS_RX_BUF_BASE : `MFS_TX_BUF_BASE;
                    if (state_d == ST_ENC || state_d == ST_DEC) begin
                        cipherStart_q <= 1'b1;
                    end
                    if (state_d == ST_SEND) begin
                        lengthWrite_q <= 1'b1;
                        lengthValue_q <= grown[7:0] -
                                         {3'h0, cipherMicLen};
                        txLaunch_q    <= 1'b1;
                    end
                end
                ST_SETUP: begin
                    // derive materials from the header
                    suiteSelect_q     <= txSecLevel;
                    authHeaderIndex_q <= `MFS_HDR_INDEX;
                    cryptPayloadIndex_q <= txPayloadStart +
                        {{(IDX_W-1){1'b0}}, txIsCmd};
                    cryptEndIndex_q   <= txLength[IDX_W-1:0];
                    nonceFill_q       <= 1'b1;
                    cipherStart_q     <= 1'b1;
                end
                ST_ENC: begin
                    if (cipherDone) begin
                        // tag appended in place; length follows
                        lengthWrite_q <= 1'b1;
                        lengthValue_q <= forSend_q ? grown[7:0]
                            : txLength + {3'h0, cipherMicLen};
                        sizeOverrun_q <= grown >
                                         {1'b0, `MFS_MAX_LEN};
                        if (forSend_q) begin
                            txLaunch_q <= 1'b1;
                        end else begin
                            netEncryptBusy_q <= 1'b0;
                        end
                    end
                end
                ST_DEC: begin
                    if (cipherDone) begin
                        decryptBusy_q <= 1'b0;
                        if (streamMode) begin
                            activeBuffer_q <= ~activeBuffer_q;
                        end
                    end
                end
                ST_SEND: begin
                    if (txSent) begin
                        transmitBusy_q <= 1'b0;
                        if (streamMode) begin
                            activeBuffer_q <= ~activeBuffer_q;
                        end
                    end
                end
                default: forSend_q <= 1'b0;
            endcase
        end
    end

    // sticky flags; a set in the clear cycle wins
    always @(posedge clk) begin
        if (srst) begin
            encryptDoneFlag_q <= 1'b0;
            decryptDoneFlag_q <= 1'b0;
            authFailFlag_q    <= 1'b0;
            idleFlag_q        <= 1'b0;
            rxFrameFlag_q     <= 1'b0;
            rxDelimiterFlag_q <= 1'b0;
            rxDiscard_q       <= 1'b0;
        end else begin
            rxDiscard_q <= rxFrameValid & rxReject;
            encryptDoneFlag_q <= (encryptDoneFlag_q & ~flagClear[0]) |
                (state_q == ST_ENC & cipherDone & ~forSend_q);
            decryptDoneFlag_q <= (decryptDoneFlag_q & ~flagClear[1]) |
                (state_q == ST_DEC & cipherDone & cipherAuthOk);
            authFailFlag_q <= (authFailFlag_q & ~flagClear[2]) |
                (state_q == ST_DEC & cipherDone & ~cipherAuthOk);
            idleFlag_q <= (idleFlag_q & ~flagClear[3]) |
                (cipherDone & (state_q == ST_DEC |
                 (state_q == ST_ENC & ~forSend_q)));
            // accepted frame flagged, decryption waits for host
            rxFrameFlag_q <= (rxFrameFlag_q & ~flagClear[4]) |
                (rxFrameValid & ~rxReject);
            rxDelimiterFlag_q <= (rxDelimiterFlag_q & ~flagClear[5]) |
                (rxFrameValid & ~rxReject);
        end
    end

    // hardware acknowledge: length, control low, control high, seq
    always @(posedge clk) begin
        if (srst) begin
            ackCnt_q  <= 3'h0;
            ackSeq_q  <= 8'h00;
            ackProp_q <= 1'b0;
        end else if (ackCnt_q == 3'h0) begin
            if (rxFrameValid & ~rxReject & rxAckReq & ~rxIsAck &
                ~rxIsStream & hwAckEnable &
                crcAppendEnable) begin
                ackCnt_q  <= 3'h4;
                ackSeq_q  <= rxSeqNum;
                ackProp_q <= propFormat;
            end
        end else if (ackPush) begin
            ackCnt_q <= ackCnt_q - 3'h1;
        end
    end

    // byte being offered to the acknowledge buffer
    always @* begin
        case (ackCnt_q)
            3'h4: ackWord = `MFS_ACK_LEN;
            3'h3: ackWord = ackProp_q ? ACK_FC_PRP[7:0]
                                      : ACK_FC_STD[7:0];
            3'h2: ackWord = ackProp_q ? ACK_FC_PRP[15:8]
                                      : ACK_FC_STD[15:8];
            3'h1: ackWord = ackSeq_q;
            default: ackWord = 8'h00;
        endcase
    end

    assign ackPush = (ackCnt_q != 3'h0) & ackInReady;

    // radio stalls are absorbed here
    mfs_two_entry_buf #(
        .WIDTH (8)
    ) uAckBuf (
        .clk      (clk),
        .srst     (srst),
        .inData   (ackWord),
        .inValid  (ackCnt_q != 3'h0),
        .inReady  (ackInReady),
        .outData  (ackByte),
        .outValid (ackValid),
        .outReady (ackReady)
    );

endmodule

// ===== testbench/mfs_chk.sv
// Purpose: port checks of the frame security sequencer
// Assumes: one clock, srst synchronous active high
// Notes:   bound to every sequencer instance
`timescale 1ns/100ps
module mfs_chk (
    input wire        clk, srst, cipherDone, cipherAuthOk, ackValid,
    input wire        cipherStart_q, cipherDecrypt_q, decryptTrigger,
    input wire        netEncryptBusy_q, transmitBusy_q, decryptBusy_q,
    input wire        encryptDoneFlag_q, decryptDoneFlag_q, txLaunch_q,
    input wire        authFailFlag_q, idleFlag_q, rxDiscard_q,
    input wire        rxFrameValid, rxFrameFlag_q, rxDelimiterFlag_q,
    input wire        propFormat, crcAppendEnable,
    input wire        dataTypeReject, commandTypeReject,
    input wire [15:0] rxFrameControl,
    input wire [9:0]  cipherBase_q,
    input wire [7:0]  lengthValue_q, txLength, ackByte,
    input wire [4:0]  cipherMicLen
);
default clocking @(posedge clk); endclocking
default disable iff (srst);
// end of a decrypt cipher run
wire decEnd = cipherDone && decryptBusy_q && cipherDecrypt_q;
wire [1:0] rt = propFormat ? rxFrameControl[7:6] : rxFrameControl[1:0];
wire stdHi = propFormat || !rxFrameControl[2];
enc_done_a: assert property (cipherDone && netEncryptBusy_q |=>
    encryptDoneFlag_q && idleFlag_q && lengthValue_q == txLength +
    cipherMicLen) else $error("encrypt end wrong");
tx_len_a: assert property (cipherDone && transmitBusy_q |=>
    txLaunch_q && lengthValue_q == txLength + cipherMicLen +
    (crcAppendEnable ? 8'h02 : 8'h00)) else $error("send length wrong");
dec_ok_a: assert property (decEnd && cipherAuthOk |=>
    decryptDoneFlag_q && idleFlag_q) else $error("decrypt done wrong");
auth_fail_a: assert property (decEnd && !cipherAuthOk |=>
    authFailFlag_q && !$rose(decryptDoneFlag_q)) else $error("auth fail");
dec_clear_a: assert property (decEnd && !decryptTrigger |=>
    !decryptBusy_q) else $error("decrypt busy stuck");
buf_base_a: assert property (cipherStart_q |-> cipherBase_q ==
    (cipherDecrypt_q ? 10'h300 : 10'h200)) else $error("base wrong");
rx_flag_a: assert property (rxFrameValid |=> rxDiscard_q ||
    rxFrameFlag_q && rxDelimiterFlag_q) else $error("rx flags wrong");
no_auto_dec_a: assert property (rxFrameValid && !decryptBusy_q &&
    !decryptTrigger |=> !decryptBusy_q) else $error("auto decrypt");
data_rej_a: assert property (rxFrameValid && dataTypeReject &&
    rt == 2'h1 && stdHi |=> rxDiscard_q) else $error("data kept");
cmd_rej_a: assert property (rxFrameValid && commandTypeReject &&
    rt == 2'h3 && stdHi |=> rxDiscard_q) else $error("command kept");
ack_len_a: assert property ($rose(ackValid) |->
    ackByte == 8'h05) else $error("ack length byte wrong");
endmodule
bind mfs_sequencer mfs_chk mfs_chk_i (.*);

// ===== testbench/mfs_partner.sv
// Purpose: cipher datapath and radio beside the sequencer
// Assumes: cipher answers after random delays, radio sends after a fixed delay and stalls at random
// Notes:   tag result only valid with done
`timescale 1ns/100ps
module mfs_partner (
    input  wire clk, srst, cipherStart_q, txLaunch_q, authOk,
    output reg  cipherDone, cipherAuthOk, txSent, ackReady
);
integer cd = 0, td = 0;
initial {cipherDone, cipherAuthOk, txSent, ackReady} = 4'h0;
// delayed answers; tag line inverted outside done
always @(posedge clk) begin
    ackReady <= $urandom % 2;
    cd <= srst ? 0 : cipherStart_q ? 2 + $urandom % 4 : cd > 0 ? cd - 1 : 0;
    td <= srst ? 0 : txLaunch_q ? 3 : td > 0 ? td - 1 : 0;
    cipherDone <= cd == 1;
    cipherAuthOk <= cd == 1 ? authOk : !authOk;
    txSent <= td == 1;
end
endmodule

// ===== testbench/mfs_sequencer_bench.sv
// Purpose: self-checking bench of the frame security sequencer
// Assumes: partner model answers cipher and radio requests
// Notes:   random receive frames with fixed seed
`timescale 1ns/100ps
module mfs_sequencer_bench;
reg clk = 0, srst = 1, netEncryptTrigger = 0, transmitStart = 0;
reg decryptTrigger = 0, manualSecuritySetup = 0, propFormat = 0;
reg dataTypeReject = 0, commandTypeReject = 0, beaconTypeReject = 0;
reg hwAckEnable = 1, crcAppendEnable = 1, txSecEnable = 1, authOk = 1;
reg rxFrameValid = 0;
reg [1:0] transceiverDirectionSelect = 2'h1;
reg [5:0] flagClear = 0;
reg [15:0] txFrameControl = 16'h0003, rxFrameControl = 0;
reg [7:0] txSecLevel = 8'h06, txPayloadStart = 8'h1D, txLength = 8'h11;
reg [7:0] rxSeqNum = 0;
reg [4:0] cipherMicLen = 5'h08;
wire netEncryptBusy_q, transmitBusy_q, decryptBusy_q, encryptDoneFlag_q;
wire decryptDoneFlag_q, authFailFlag_q, idleFlag_q, rxFrameFlag_q;
wire rxDelimiterFlag_q, nonceFill_q, cipherStart_q, cipherDecrypt_q;
wire lengthWrite_q, sizeOverrun_q, txLaunch_q, rxDiscard_q, ackValid;
wire activeBuffer_q, cipherDone, cipherAuthOk, txSent, ackReady;
wire [7:0] suiteSelect_q, authHeaderIndex_q, cryptPayloadIndex_q;
wire [7:0] cryptEndIndex_q, lengthValue_q, ackByte;
wire [9:0] cipherBase_q;
integer n_errors = 0, samples_checked = 0, cyc = 0, i, j;
mfs_sequencer mfs_sequencer_i (.*);
mfs_partner mfs_partner_i (.*);
initial forever #5 clk = ~clk;
task check(input [7:0] got, input [7:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    end
endtask
task wrap_up;
    begin
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    end
endtask
// pulse one trigger with flags cleared, wait until idle again
task run(input [1:0] op);
    integer k;
    begin
        @(posedge clk);
        flagClear <= 6'h3F;
        {netEncryptTrigger, transmitStart, decryptTrigger} <= 3'h4 >> op;
        @(posedge clk);
        {netEncryptTrigger, transmitStart, decryptTrigger} <= 3'h0;
        flagClear <= 6'h00;
        for (k = 0; k < 60 && (k < 2 || (netEncryptBusy_q | transmitBusy_q
             | decryptBusy_q) !== 1'b0); k = k + 1) @(posedge clk) #1;
        check(netEncryptBusy_q | transmitBusy_q | decryptBusy_q, 0);
    end
endtask
function disc(input p, d, c, b, input [15:0] f);
    disc = p ? (f[7:6] == 1 && d) || (f[7:6] == 3 && c)
             : (f[2:0] == 1 && d) || (f[2:0] == 3 && c) || (f[2:0] == 0 && b);
endfunction
// acknowledge wanted: requested, not ack or stream type, hw ack on
function ackOn(input p, h, input [15:0] f);
    ackOn = h && (p ? f[13] && f[7:6] != 2 && f[7:6] != 0
                    : f[5] && f[2:0] != 2);
endfunction
// acknowledge bytes: length, control low, control high, sequence
function [7:0] ackExp(input integer n, input p, input [7:0] s);
    ackExp = n == 0 ? 8'h05 : n == 1 ? (p ? 8'h80 : 8'h02)
           : n == 2 ? 8'h00 : s;
endfunction
// hang guard
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
        n_errors = n_errors + 1;
        wrap_up;
    end
end
initial begin
    i = $urandom(38);
    repeat (2) @(posedge clk);
    srst <= 0;
    #1 check(idleFlag_q, 0);
    run(0); // network encrypt alone
    check(encryptDoneFlag_q & idleFlag_q, 1);
    check(lengthValue_q, txLength + cipherMicLen);
    for (i = 0; i < 2; i = i + 1) begin
        @(posedge clk);
        txSecEnable <= i; // security off, then on with auto setup, manual bit clear
        cipherMicLen <= i ? 5'h08 : 5'h00;
        run(1);
        check(lengthValue_q, txLength + cipherMicLen + 8'h02);
        check(activeBuffer_q, 1);
        authOk <= i;
        run(2);
        check(decryptDoneFlag_q, i);
        check(authFailFlag_q, !i);
        check(decryptBusy_q, 0);
    end
    check(suiteSelect_q, txSecLevel);
    check(authHeaderIndex_q, 8'h01);
    check(cryptPayloadIndex_q, txPayloadStart + 8'h01);
    check(cryptEndIndex_q, txLength);
    check(sizeOverrun_q, 0);
    $display("security runs done");
    for (i = 0; i < 40; i = i + 1) begin
        @(posedge clk);
        {propFormat, dataTypeReject, commandTypeReject} <= $urandom;
        {beaconTypeReject, hwAckEnable, transceiverDirectionSelect} <= $urandom;
        rxFrameControl <= $urandom;
        rxSeqNum <= $urandom;
        rxFrameValid <= 1;
        @(posedge clk);
        rxFrameValid <= 0;
        #1 check(rxDiscard_q, disc(propFormat, dataTypeReject,
            commandTypeReject, beaconTypeReject, rxFrameControl));
        j = 0;
        repeat (30) begin
            @(posedge clk) #1;
            if (ackValid && ackReady) begin
                check(ackByte, ackExp(j, propFormat, rxSeqNum));
                j = j + 1;
            end
        end
        check(j, ackOn(propFormat, hwAckEnable, rxFrameControl) &&
            !disc(propFormat, dataTypeReject, commandTypeReject,
            beaconTypeReject, rxFrameControl) ? 4 : 0);
    end
    $display("receive filtering done");
    wrap_up;
end
endmodule
